// ===== hfadc_pkg.sv
// Package of timing constants and enumerations for the half-flash converter host controller
package hfadc_pkg;
    // ========================================
    // Clock
    localparam int unsigned CLK_PERIOD_NS = 10;
    // ========================================
    // Timing figures in nanoseconds
    localparam int unsigned WAKE_NS = 900;             // Power-up plus acquisition after wake
    localparam int unsigned TRACK_INTERVAL_NS = 600;   // Acquisition between done and next start
    localparam int unsigned START_WIDTH_NS = 660;      // Start strobe low width
    localparam int unsigned AUTO_FINISH_DELAY_NS = 1600; // Longest start-rise to done delay
    localparam int unsigned EARLY_GAP_NS = 900;        // Start rise to early read strobe
    localparam int unsigned READ_WIDTH_NS = 500;       // Read strobe width, covers data access
    // ========================================
    // Cycle counts, least times rounded up
    localparam int unsigned WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TRACK_CYC = (TRACK_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned START_CYC = (START_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AUTO_CYC = (AUTO_FINISH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EARLY_CYC = (EARLY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned READ_CYC = (READ_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ========================================
    // Widths
    localparam int unsigned CNT_W = 9;
    localparam int unsigned DATA_W = 8;
    // ========================================
    // Conversion styles
    typedef enum logic [1:0]
    {
        HFADC_STY_READ,
        HFADC_STY_WAIT_DONE,
        HFADC_STY_EARLY
    } hfadc_style_t;
    // ========================================
    // Sequencer states
    typedef enum logic [3:0]
    {
        HFADC_ST_SLEEP,
        HFADC_ST_WAKE,
        HFADC_ST_IDLE,
        HFADC_ST_START_LO,
        HFADC_ST_START_HI,
        HFADC_ST_RD_WAIT,
        HFADC_ST_READ,
        HFADC_ST_TRACK
    } hfadc_state_t;
endpackage

// ===== hfadc_host.sv
// Host sequencer that drives the half-flash converter through its pins
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE_01] Device resolves upper then lower nibble
// [RULE_02] Sleep low shuts down, high wakes
// [RULE_03] Wait 900ns after wake before starting
// [RULE_04] Mode low read, high write-read
// [RULE_05] Read-mode conversion starts on read strobe
// [RULE_06] Ready open-drain low until conversion ends
// [RULE_07] Read-mode done low at end, cleared
// [RULE_08] Hold read strobe low until ready
// [RULE_09] Write-read conversion starts at start fall
// [RULE_10] Start rise latches upper nibble
// [RULE_11] Conversion end latches lower nibble, done
// [RULE_12] Read with chip select low gets result
// [RULE_13] Keep acquisition interval after done low
// [RULE_14] Done low after internal delay
// [RULE_15] Done cleared by strobe rise
// [RULE_16] Early read finishes conversion early
// [RULE_17] Early read drives done low
// [RULE_18] Stand-alone: chip select, read tied low
// [RULE_19] Straight binary output coding
// [RULE_20] Sleep: mode low, inputs high
// [RULE_21] Strobes ignored without chip select
// [RULE_22] Mode pin defaults low
// [RULE_23] Data bus tri-stated outside reads; the model drives the inverted latch instead
module hfadc_host
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req_start,
    input wire logic [1:0] req_style,
    input wire logic req_sleep,
    input wire logic [7:0] result_bits,
    input wire logic ready_in,
    input wire logic done_n_in,
    output logic sleep_n,
    output logic mode,
    output logic cs_n,
    output logic rd_n,
    output logic start_n,
    output logic start_oe_n,
    output logic busy,
    output logic sample_valid,
    output logic [7:0] sample
);
    // ========================================
    // Pin synchronisers: three stages, change counts when stage 2 and 3 agree
    logic [7:0] data_s1_q, data_s2_q, data_s3_q;
    logic [7:0] data_stable_q;
    logic [2:0] ready_s_q, done_s_q;
    logic ready_f_q, done_f_q;
    // Sequencer state
    hfadc_pkg::hfadc_state_t state_q, state_d;
    hfadc_pkg::hfadc_style_t style_q;
    logic [hfadc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic sample_now;

    // Sync chains on all pins from the device
    always_ff @(posedge clk_sys)
    begin
        data_s1_q <= result_bits;
        data_s2_q <= data_s1_q;
        data_s3_q <= data_s2_q;
        ready_s_q <= {ready_s_q[1:0], ready_in};
        done_s_q <= {done_s_q[1:0], done_n_in};
    end

    // Filtered levels, updated only when the last two stages agree
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            data_stable_q <= 8'h00;
            ready_f_q <= 1'b1;
            done_f_q <= 1'b1;
        end
        else
        begin
            if (data_s2_q == data_s3_q)
                data_stable_q <= data_s3_q;
            if (ready_s_q[1] == ready_s_q[2])
                ready_f_q <= ready_s_q[2];
            if (done_s_q[1] == done_s_q[2])
                done_f_q <= done_s_q[2];
        end
    end

    // ========================================
    // Decoding
    wire cnt_zero = (cnt_q == '0);
    wire ready_hi = ready_f_q;
    wire done_lo = !done_f_q;
    wire is_read = (style_q == hfadc_pkg::HFADC_STY_READ);
    wire is_early = (style_q == hfadc_pkg::HFADC_STY_EARLY);

    // Loads a count from a cycle figure at the counter width
    function automatic logic [hfadc_pkg::CNT_W-1:0] cyc(input int unsigned n);
        cyc = hfadc_pkg::CNT_W'(n - 1);
    endfunction

    // Next-state logic
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
        sample_now = 1'b0;
        unique case (state_q)
            hfadc_pkg::HFADC_ST_SLEEP:
            begin
                // Leave shutdown on release of sleep request
                if (!req_sleep)
                begin
                    state_d = hfadc_pkg::HFADC_ST_WAKE; // RULE_02
                    cnt_d = cyc(hfadc_pkg::WAKE_CYC); // RULE_03
                end
            end
            hfadc_pkg::HFADC_ST_WAKE:
            begin
                // Power-up and acquisition wait
                if (cnt_zero)
                    state_d = hfadc_pkg::HFADC_ST_IDLE; // RULE_03
            end
            hfadc_pkg::HFADC_ST_IDLE:
            begin
                if (req_sleep)
                    state_d = hfadc_pkg::HFADC_ST_SLEEP;
                else if (req_start && req_style == 2'(hfadc_pkg::HFADC_STY_READ))
                    state_d = hfadc_pkg::HFADC_ST_RD_WAIT; // RULE_05
                else if (req_start)
                begin
                    state_d = hfadc_pkg::HFADC_ST_START_LO; // RULE_09
                    cnt_d = cyc(hfadc_pkg::START_CYC);
                end
            end
            hfadc_pkg::HFADC_ST_START_LO:
            begin
                // Start strobe low width
                if (cnt_zero)
                begin
                    state_d = hfadc_pkg::HFADC_ST_START_HI; // RULE_10
                    cnt_d = is_early ? cyc(hfadc_pkg::EARLY_CYC) : cyc(hfadc_pkg::AUTO_CYC);
                end
            end
            hfadc_pkg::HFADC_ST_START_HI:
            begin
                // Early read after fixed gap, or wait for done
                if (is_early ? cnt_zero : (done_lo || cnt_zero))
                begin
                    state_d = hfadc_pkg::HFADC_ST_READ; // RULE_14 RULE_16
                    cnt_d = cyc(hfadc_pkg::READ_CYC);
                end
            end
            hfadc_pkg::HFADC_ST_RD_WAIT:
            begin
                // Read strobe held low until ready releases high and done is low
                if (ready_hi && done_lo)
                begin
                    state_d = hfadc_pkg::HFADC_ST_READ; // RULE_08
                    cnt_d = cyc(hfadc_pkg::READ_CYC);
                end
            end
            hfadc_pkg::HFADC_ST_READ:
            begin
                // Data sampled at end of the read strobe
                if (cnt_zero)
                begin
                    sample_now = 1'b1; // RULE_12
                    state_d = hfadc_pkg::HFADC_ST_TRACK; // RULE_13
                    cnt_d = cyc(hfadc_pkg::TRACK_CYC);
                end
            end
            hfadc_pkg::HFADC_ST_TRACK:
            begin
                // Acquisition interval before a new start
                if (cnt_zero)
                    state_d = hfadc_pkg::HFADC_ST_IDLE; // RULE_13
            end
            default:
                state_d = hfadc_pkg::HFADC_ST_SLEEP;
        endcase
    end

    // ========================================
    // Pin values of each state
    wire in_sleep_d = (state_d == hfadc_pkg::HFADC_ST_SLEEP);
    wire cs_d = (state_d == hfadc_pkg::HFADC_ST_START_LO) || (state_d == hfadc_pkg::HFADC_ST_START_HI)
             || (state_d == hfadc_pkg::HFADC_ST_RD_WAIT) || (state_d == hfadc_pkg::HFADC_ST_READ);
    wire rd_d = (state_d == hfadc_pkg::HFADC_ST_RD_WAIT) || (state_d == hfadc_pkg::HFADC_ST_READ);
    wire mode_d = !in_sleep_d && !((state_d == hfadc_pkg::HFADC_ST_RD_WAIT)
                  || (state_d == hfadc_pkg::HFADC_ST_READ && is_read)
                  || (state_d == hfadc_pkg::HFADC_ST_IDLE) || (state_d == hfadc_pkg::HFADC_ST_WAKE)
                  || (state_d == hfadc_pkg::HFADC_ST_TRACK && is_read));
    wire start_drive_d = mode_d || in_sleep_d;

    // State, counter and style registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= hfadc_pkg::HFADC_ST_SLEEP;
            cnt_q <= '0;
            style_q <= hfadc_pkg::HFADC_STY_READ;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (state_q == hfadc_pkg::HFADC_ST_IDLE && req_start)
                style_q <= hfadc_pkg::hfadc_style_t'(req_style);
        end
    end

    // Registered pin and user outputs
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sleep_n <= 1'b0;
            mode <= 1'b0;
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            start_n <= 1'b1;
            start_oe_n <= 1'b0;
            busy <= 1'b0;
            sample_valid <= 1'b0;
            sample <= 8'h00;
        end
        else
        begin
            sleep_n <= !in_sleep_d; // RULE_02
            mode <= mode_d; // RULE_04 RULE_20 RULE_22
            cs_n <= !cs_d; // RULE_21
            rd_n <= !rd_d; // RULE_05 RULE_12
            start_n <= !(state_d == hfadc_pkg::HFADC_ST_START_LO); // RULE_09 RULE_20
            start_oe_n <= !start_drive_d; // RULE_06
            busy <= !(state_d == hfadc_pkg::HFADC_ST_IDLE);
            sample_valid <= sample_now;
            if (sample_now)
                sample <= data_stable_q; // RULE_19
        end
    end

    // ========================================
    // Assertions
    logic [hfadc_pkg::CNT_W-1:0] wake_age_q, track_age_q;
    // Saturating ages since wake and since the read strobe last rose
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !sleep_n)
            wake_age_q <= '0;
        else if (wake_age_q != '1)
            wake_age_q <= wake_age_q + 1'b1;
        if (!rst_n || !rd_n)
            track_age_q <= '0;
        else if (track_age_q != '1)
            track_age_q <= track_age_q + 1'b1;
    end

    a_wake_before_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(start_n) || $fell(rd_n)) |-> wake_age_q >= hfadc_pkg::CNT_W'(hfadc_pkg::WAKE_CYC)) // RULE_03
        else $error("conversion started too soon after wake");
    a_start_pulse_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(start_n) |-> !start_n [*8]) // RULE_09
        else $error("start strobe too short");
    a_start_with_cs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !start_n |-> !cs_n && mode && !start_oe_n) // RULE_21
        else $error("start strobe without chip select");
    a_read_with_cs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !rd_n |-> !cs_n) // RULE_12
        else $error("read strobe without chip select");
    a_ready_released: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !rd_n && !mode |-> start_oe_n) // RULE_06
        else $error("host drives shared ready pin in read mode");
    a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sleep_n |-> !mode && cs_n && rd_n && start_n) // RULE_20
        else $error("inputs not parked during shutdown");
    a_track_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(start_n) || $fell(rd_n)) |-> track_age_q >= hfadc_pkg::CNT_W'(hfadc_pkg::TRACK_CYC)) // RULE_13
        else $error("acquisition interval violated");
    a_sample_on_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_valid |-> !$past(rd_n) && $rose(rd_n)) // RULE_12
        else $error("sample taken outside read strobe");
    a_mode_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cs_n && !$past(cs_n) |-> $stable(mode)) // RULE_04
        else $error("mode changed during access");

    c_read_mode: cover property (@(posedge clk_sys) disable iff (!rst_n)
        sample_valid && !mode);
    c_write_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(start_n) ##[1:600] sample_valid);
    c_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(sleep_n));
endmodule
`default_nettype wire

// ===== hfadc_dev_model.sv
// Behavioural model of the converter pins as seen by the host sequencer
`timescale 1ns/1ps
`default_nettype none
module hfadc_dev_model
#(
    parameter int CONV_NS = 1200, // Read-mode conversion time
    parameter int AUTO_NS = 1000, // Start rise to done, internal delay
    parameter int RI_NS = 300, // Early read strobe to done
    parameter int WAKE_NS = 900, // Power-up plus acquisition
    parameter int TRACK_NS = 600 // Acquisition between conversions
)
(
    input wire logic sleep_n,
    input wire logic mode,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic start_pin,
    input wire logic [7:0] code,
    output logic ready_low,
    output logic done_n,
    output logic [7:0] data,
    output logic viol
);
    logic [7:0] latch_q = 8'h00; // Output latch
    logic conv = 1'b0; // Conversion running
    realtime t_wake = 0.0; // Last wake time
    realtime t_done = -1.0e6; // Last end of conversion
    logic early = 1'b0; // Read strobe cut the internal delay short
    wire wr_mode = (mode === 1'b1); // Undriven mode reads low, so read mode
    initial
    begin
        ready_low = 1'b0;
        done_n = 1'b1;
        viol = 1'b0;
    end
    // Released bus shows the inverse, buffers only on a live read
    assign data = (sleep_n && !cs_n && !rd_n && !conv) ? latch_q : ~latch_q;
    // Host must respect wake and track times before a start
    task automatic begin_conv();
        if ($realtime - t_wake < WAKE_NS || $realtime - t_done < TRACK_NS)
            viol = 1'b1;
        conv = 1'b1;
        early = 1'b0;
        done_n = 1'b1;
    endtask
    // Lower nibble lands last, done goes low
    task automatic finish();
        latch_q[3:0] = code[3:0];
        if (!wr_mode)
            latch_q[7:4] = code[7:4];
        conv = 1'b0;
        done_n = 1'b0;
        t_done = $realtime;
    endtask
    always @(posedge sleep_n) t_wake = $realtime;
    // Inputs should idle high with mode low while asleep
    always @(negedge sleep_n or mode or cs_n or rd_n or start_pin)
    begin
        #1;
        if (!sleep_n && (wr_mode || !cs_n || !rd_n || !start_pin))
            viol = 1'b1;
    end
    // Ready pulled low once selected in read mode
    always @(negedge cs_n)
    begin
        #1;
        if (sleep_n && !wr_mode)
            ready_low = 1'b1;
    end
    // Read strobe starts a read-mode conversion or cuts the delay short
    always @(negedge rd_n)
    begin
        #1;
        if (sleep_n && !cs_n && !wr_mode)
        begin
            begin_conv();
            #(CONV_NS);
            finish();
            ready_low = 1'b0;
        end
        else if (sleep_n && !cs_n && conv && start_pin)
        begin
            early = 1'b1;
            #(RI_NS);
            finish();
        end
    end
    always @(posedge rd_n) if (conv && !wr_mode) viol = 1'b1;
    always @(posedge rd_n or posedge cs_n) done_n = 1'b1;
    // Start fall begins a write-read conversion
    always @(negedge start_pin)
    begin
        #1;
        if (sleep_n && wr_mode && !cs_n)
            begin_conv();
    end
    // Start rise latches upper nibble, internal delay ends it
    always @(posedge start_pin)
    begin
        if (sleep_n && wr_mode && !cs_n && conv)
        begin
            latch_q[7:4] = code[7:4];
            #(AUTO_NS);
            if (conv && !early)
                finish();
        end
    end
endmodule
`default_nettype wire

// ===== half_flash_adc_host_port_bench.sv
// Self-checking bench for the converter host sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module half_flash_adc_host_port_bench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_start = 1'b0;
    logic req_sleep = 1'b0;
    logic [1:0] req_style = 2'h0;
    logic [7:0] code = 8'h00; // Analog input as a code
    logic sleep_n, mode, cs_n, rd_n, start_n, start_oe_n, busy, sample_valid;
    logic [7:0] sample;
    logic ready_low, done_n, viol;
    logic [7:0] data;
    wire start_pin; // Shared start/ready line
    int n_errors = 0;
    int n_compared = 0;
    // Pull-up on the released ready line
    assign start_pin = start_oe_n ? !ready_low : start_n;
    hfadc_host u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_start(req_start), .req_style(req_style),
        .req_sleep(req_sleep), .result_bits(data), .ready_in(start_pin), .done_n_in(done_n),
        .sleep_n(sleep_n), .mode(mode), .cs_n(cs_n), .rd_n(rd_n), .start_n(start_n),
        .start_oe_n(start_oe_n), .busy(busy), .sample_valid(sample_valid), .sample(sample));
    hfadc_dev_model u_dev (.sleep_n(sleep_n), .mode(mode), .cs_n(cs_n), .rd_n(rd_n), .start_pin(start_pin),
        .code(code), .ready_low(ready_low), .done_n(done_n), .data(data), .viol(viol));
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Verdict and end of run
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait for the sequencer to go idle
    task automatic idle_wait();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300)
        begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(busy, 1'b0)
    endtask
    // One conversion in the given style, result checked against the code
    task automatic convert(input logic [1:0] sty, input logic [7:0] val);
        int n;
        idle_wait();
        @(posedge clk_sys);
        code <= val;
        req_style <= sty;
        req_start <= 1'b1;
        n = 0;
        do begin @(negedge clk_sys); n++; end while (busy !== 1'b1 && n < 10);
        @(posedge clk_sys);
        req_start <= 1'b0;
        @(negedge clk_sys);
        `CHK(mode, (sty != 2'h0))
        `CHK(start_oe_n, (sty == 2'h0))
        n = 0;
        do begin @(negedge clk_sys); n++; end while (sample_valid !== 1'b1 && n < 2000);
        `CHK(sample_valid, 1'b1)
        `CHK(sample, val)
        `CHK({cs_n, rd_n}, 2'b11)
        `CHK(viol, 1'b0)
    endtask
    // Shut down in idle, then wake again
    task automatic nap();
        idle_wait();
        @(posedge clk_sys);
        req_sleep <= 1'b1;
        repeat (20) @(negedge clk_sys);
        `CHK(sleep_n, 1'b0)
        `CHK({mode, cs_n, rd_n, start_n}, 4'b0111)
        @(posedge clk_sys);
        req_sleep <= 1'b0;
    endtask
    // Main sequence: corners first, then random styles and codes
    initial
    begin
        void'($urandom(32'hd37c8f45));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(busy, 1'b1)
        `CHK(sleep_n, 1'b1)
        convert(2'h0, 8'h00);
        convert(2'h1, 8'hff);
        convert(2'h2, 8'h0f);
        convert(2'h2, 8'hf0);
        nap();
        convert(2'h1, 8'ha5);
        for (int i = 0; i < 24; i++)
        begin
            convert(2'($urandom_range(2, 0)), 8'($urandom));
            if (i % 8 == 7)
                nap();
        end
        `CHK(viol, 1'b0)
        stop_test();
    end
    // Watchdog for a hung sequence
    initial
    begin
        #600000;
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
